/* File: byte_exec_pkg.sv */
// Purpose: Shared constants for the byte-op and table-read executor
// Assumes: 16-bit instruction words, 8-bit data, 21-bit table pointer
// Notes: Opcode patterns, address layout and flag positions live here
package byte_exec_pkg;
  localparam int DATA_W = 8;
  localparam int INSTR_W = 16;
  localparam int BANK_W = 4;
  localparam int DADDR_W = 12;
  localparam int TP_W = 21;
  localparam int PADDR_W = 20;
  localparam int PWORD_W = 16;
  localparam int STATUS_W = 5;

  // Opcode patterns
  localparam logic [7:0] OP_OR_IMM = 8'h09;
  localparam logic [5:0] OP_OR_REG = 6'h04;
  localparam logic [5:0] OP_SUB_BORROW = 6'h16;
  localparam logic [5:0] OP_SWAP = 6'h0E;
  localparam logic [13:0] OP_TBL_READ = 14'h0002;

  // Instruction field positions
  localparam int POS_DEST = 9;
  localparam int POS_ACCESS = 8;

  // Table read modes
  localparam logic [1:0] TBL_KEEP = 2'h0;
  localparam logic [1:0] TBL_POST_INC = 2'h1;
  localparam logic [1:0] TBL_POST_DEC = 2'h2;
  localparam logic [1:0] TBL_PRE_INC = 2'h3;

  // Shared access region split and its lower and upper banks
  localparam logic [7:0] ACCESS_LOW_LAST = 8'h5F;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

  // Status flag positions
  localparam int FLAG_C = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_N = 4;

  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [STATUS_W-1:0] STATUS_RESET = 5'h00;
  localparam logic [TP_W-1:0] TP_RESET = 21'h000000;
  localparam logic [TP_W-1:0] TP_ONE = 21'h000001;
endpackage

/* File: byte_op_and_table_read_exec.sv */
// Purpose: Executes literal OR, register OR, subtract with borrow,
//   nibble swap and program table read for an 8-bit core
// Assumes: Memories answer one clock after a read enable
// Notes: One instruction cycle is four clocks, Q1 to Q4
//
// What this block does
// - Literal OR: accumulator OR 8-bit immediate into accumulator; N, Z only.
// - Register OR: accumulator OR register into chosen destination; N, Z only.
// - Destination bit 0 writes accumulator, 1 writes the register back.
// - Access bit 0 uses shared region, 1 uses bank select register.
// - Access 0 with extended set and address <= 95 uses indexed offset.
// - Nibble swap exchanges register halves into destination; no flags change.
// - Table read mode: 0 keep, 1 post-inc, 2 post-dec, 3 pre-inc.
// - Table read copies addressed program byte into table latch; pointer adjusted.
// - Table read takes two cycles; read and latch write in the second.
`timescale 1ns/1ps
`default_nettype none
module byte_op_and_table_read_exec
  import byte_exec_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic instr_valid,
  input wire logic [INSTR_W-1:0] instr,
  input wire logic ext_set_en,
  input wire logic [BANK_W-1:0] bank_select_register,
  input wire logic [DADDR_W-1:0] index_base,
  input wire logic [DATA_W-1:0] data_rdata,
  input wire logic [PWORD_W-1:0] prog_rdata,
  output logic busy,
  output logic [DADDR_W-1:0] data_addr,
  output logic data_rd_en,
  output logic data_wr_en,
  output logic [DATA_W-1:0] data_wdata,
  output logic [PADDR_W-1:0] prog_addr,
  output logic prog_rd_en,
  output logic [DATA_W-1:0] accumulator,
  output logic [STATUS_W-1:0] status,
  output logic [TP_W-1:0] table_pointer,
  output logic [DATA_W-1:0] table_latch
);

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_Q1 = 5'b00010,
    ST_Q2 = 5'b00100,
    ST_Q3 = 5'b01000,
    ST_Q4 = 5'b10000
  } phase_e;

  phase_e state, next_state;
  logic second, next_second;
  logic [INSTR_W-1:0] instr_q, next_instr_q;
  logic next_busy;
  logic [DADDR_W-1:0] next_data_addr;
  logic next_data_rd_en, next_data_wr_en;
  logic [DATA_W-1:0] next_data_wdata;
  logic [PADDR_W-1:0] next_prog_addr;
  logic next_prog_rd_en;
  logic [DATA_W-1:0] next_accumulator;
  logic [STATUS_W-1:0] next_status;
  logic [TP_W-1:0] next_table_pointer;
  logic [DATA_W-1:0] next_table_latch;

  logic is_or_imm, is_or_reg, is_sub, is_swap, is_tbl, is_byte_op;
  logic [1:0] tbl_mode;
  logic [DATA_W-1:0] freg;
  logic [DADDR_W-1:0] operand_addr;

  always_comb begin
    is_or_imm = (instr_q[15:8] == OP_OR_IMM);
    is_or_reg = (instr_q[15:10] == OP_OR_REG);
    is_sub = (instr_q[15:10] == OP_SUB_BORROW);
    is_swap = (instr_q[15:10] == OP_SWAP);
    is_tbl = (instr_q[15:2] == OP_TBL_READ);
    is_byte_op = is_or_reg | is_sub | is_swap;
    tbl_mode = instr_q[1:0];
    freg = instr_q[DATA_W-1:0];
    if (instr_q[POS_ACCESS]) begin
      operand_addr = {bank_select_register, freg};
    end else if (ext_set_en && (freg <= ACCESS_LOW_LAST)) begin
      operand_addr = index_base + {{(DADDR_W-DATA_W){1'b0}}, freg};
    end else if (freg <= ACCESS_LOW_LAST) begin
      operand_addr = {ACCESS_LOW_BANK, freg};
    end else begin
      operand_addr = {ACCESS_HIGH_BANK, freg};
    end
  end

  always_comb begin
    logic [DATA_W-1:0] opnd;
    logic [DATA_W-1:0] result;
    logic [DATA_W:0] sum9;
    logic [4:0] nib5;
    logic [TP_W-1:0] tp_read;
    opnd = data_rdata;
    result = '0;
    sum9 = '0;
    nib5 = '0;
    tp_read = table_pointer;
    next_state = state;
    next_second = second;
    next_instr_q = instr_q;
    next_busy = busy;
    next_data_addr = data_addr;
    next_data_rd_en = 1'b0;
    next_data_wr_en = 1'b0;
    next_data_wdata = data_wdata;
    next_prog_addr = prog_addr;
    next_prog_rd_en = 1'b0;
    next_accumulator = accumulator;
    next_status = status;
    next_table_pointer = table_pointer;
    next_table_latch = table_latch;
    case (state)
      ST_IDLE: begin
        if (instr_valid) begin
          next_instr_q = instr;
          next_second = 1'b0;
          next_busy = 1'b1;
          next_state = ST_Q1;
        end
      end
      ST_Q1: begin
        if (is_byte_op) begin
          next_data_addr = operand_addr;
          next_data_rd_en = 1'b1;
        end
        if (is_tbl && second) begin
          if (tbl_mode == TBL_PRE_INC) begin
            tp_read = table_pointer + TP_ONE;
          end
          next_table_pointer = tp_read;
          next_prog_addr = tp_read[TP_W-1:1];
          next_prog_rd_en = 1'b1;
        end
        if (is_or_imm || is_byte_op || is_tbl) begin
          next_state = ST_Q2;
        end else begin
          next_busy = 1'b0;
          next_state = ST_IDLE;
        end
      end
      ST_Q2: begin
        next_state = ST_Q3;
      end
      ST_Q3: begin
        if (is_or_imm) begin
          opnd = freg;
        end
        sum9 = {1'b0, opnd} + {1'b0, ~accumulator} + {{DATA_W{1'b0}}, status[FLAG_C]};
        nib5 = {1'b0, opnd[3:0]} + {1'b0, ~accumulator[3:0]} + {4'h0, status[FLAG_C]};
        if (is_sub) begin
          result = sum9[DATA_W-1:0];
          next_status[FLAG_C] = sum9[DATA_W];
          next_status[FLAG_DC] = nib5[4];
          next_status[FLAG_OV] = (opnd[7] != accumulator[7]) && (result[7] != opnd[7]);
        end else if (is_swap) begin
          result = {opnd[3:0], opnd[7:4]};
        end else begin
          result = opnd | accumulator;
        end
        if (is_or_imm || is_or_reg || is_sub) begin
          next_status[FLAG_Z] = (result == '0);
          next_status[FLAG_N] = result[7];
        end
        if (is_or_imm || (is_byte_op && !instr_q[POS_DEST])) begin
          next_accumulator = result;
        end else if (is_byte_op) begin
          next_data_wr_en = 1'b1;
          next_data_wdata = result;
        end
        // Byte select by pointer bit 0
        if (is_tbl && second) begin
          next_table_latch = table_pointer[0] ? prog_rdata[15:8] : prog_rdata[7:0];
        end
        next_state = ST_Q4;
      end
      ST_Q4: begin
        if (is_tbl && !second) begin
          next_second = 1'b1;
          next_state = ST_Q1;
        end else begin
          if (is_tbl && tbl_mode == TBL_POST_INC) begin
            next_table_pointer = table_pointer + TP_ONE;
          end else if (is_tbl && tbl_mode == TBL_POST_DEC) begin
            next_table_pointer = table_pointer - TP_ONE;
          end
          next_busy = 1'b0;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_busy = 1'b0;
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state <= ST_IDLE;
      second <= 1'b0;
      instr_q <= '0;
      busy <= 1'b0;
      data_addr <= '0;
      data_rd_en <= 1'b0;
      data_wr_en <= 1'b0;
      data_wdata <= '0;
      prog_addr <= '0;
      prog_rd_en <= 1'b0;
      accumulator <= ACC_RESET;
      status <= STATUS_RESET;
      table_pointer <= TP_RESET;
      table_latch <= '0;
    end else begin
      state <= next_state;
      second <= next_second;
      instr_q <= next_instr_q;
      busy <= next_busy;
      data_addr <= next_data_addr;
      data_rd_en <= next_data_rd_en;
      data_wr_en <= next_data_wr_en;
      data_wdata <= next_data_wdata;
      prog_addr <= next_prog_addr;
      prog_rd_en <= next_prog_rd_en;
      accumulator <= next_accumulator;
      status <= next_status;
      table_pointer <= next_table_pointer;
      table_latch <= next_table_latch;
    end
  end

endmodule
`default_nettype wire

/* File: byte_op_and_table_read_exec_bench.sv */
// Purpose: Self-checking bench for the byte-op and table-read executor
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Random operands from a fixed seed plus corner cases
`timescale 1ns/1ps
`default_nettype none
module byte_op_and_table_read_exec_bench;
  import byte_exec_pkg::*;
  logic ref_clk = 0, resetn = 0, instr_valid = 0, ext_set_en = 0;
  logic [INSTR_W-1:0] instr = '0;
  logic [BANK_W-1:0] bank_select_register = '0;
  logic [DADDR_W-1:0] index_base = '0, data_addr;
  logic [DATA_W-1:0] data_rdata, data_wdata, accumulator, table_latch, w;
  logic [PWORD_W-1:0] prog_rdata;
  logic [PADDR_W-1:0] prog_addr;
  logic [STATUS_W-1:0] status, st;
  logic [TP_W-1:0] table_pointer, tp;
  logic busy, data_rd_en, data_wr_en, prog_rd_en;
  logic [5:0] ops [4] = '{6'h00, OP_OR_REG, OP_SUB_BORROW, OP_SWAP};
  int num_errors = 0, checks_done = 0, cyc = 0;
  always #5 ref_clk = ~ref_clk;
  byte_op_and_table_read_exec byte_op_and_table_read_exec_i (.ref_clk, .resetn, .instr_valid,
    .instr, .ext_set_en, .bank_select_register, .index_base, .data_rdata, .prog_rdata, .busy,
    .data_addr, .data_rd_en, .data_wr_en, .data_wdata, .prog_addr, .prog_rd_en, .accumulator,
    .status, .table_pointer, .table_latch);
  mem_model mem_model_i (.ref_clk, .data_addr, .data_rd_en, .data_wr_en, .data_wdata,
    .data_rdata, .prog_addr, .prog_rd_en, .prog_rdata);
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    checks_done++;
    if (e !== s) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic issue(logic [INSTR_W-1:0] i);
    instr_valid = 1;
    instr = i;
    @(posedge ref_clk) #1;
    instr_valid = 0;
    @(posedge ref_clk) #1;
    for (int n = 0; n < 20 && busy !== 1'b0; n++) @(posedge ref_clk) #1;
  endtask
  function automatic logic [7:0] pbyte(logic [TP_W-1:0] p);
    return p[0] ? p[8:1] ^ 8'hC3 : p[8:1] + 8'h11;
  endfunction
  task automatic byte_op(int k, logic [7:0] f, logic d, logic a, logic [7:0] v);
    logic [DADDR_W-1:0] ad;
    logic [8:0] r;
    logic [4:0] lo;
    ad = a ? {bank_select_register, f} : (ext_set_en && f <= ACCESS_LOW_LAST) ? index_base + f
      : {(f <= ACCESS_LOW_LAST) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK, f};
    mem_model_i.mem[ad] = v;
    case (k)
      0: r = {1'b0, w | f};
      1: r = {1'b0, w | v};
      2: begin
        r = v + {1'b0, ~w} + st[FLAG_C];
        lo = v[3:0] + {1'b0, ~w[3:0]} + st[FLAG_C];
        st[FLAG_C] = r[8];
        st[FLAG_DC] = lo[4];
        st[FLAG_OV] = (v[7] != w[7]) && (r[7] != v[7]);
      end
      default: r = {1'b0, v[3:0], v[7:4]};
    endcase
    if (k != 3) st[FLAG_N] = r[7];
    if (k != 3) st[FLAG_Z] = r[7:0] == 8'h00;
    issue(k == 0 ? {OP_OR_IMM, f} : {ops[k], d, a, f});
    if (k == 0 || !d) w = r[7:0];
    chk("accumulator", w, accumulator);
    chk("status", st, status);
    chk("register", (k != 0 && d) ? r[7:0] : v, mem_model_i.mem[ad]);
  endtask
  task automatic tbl(logic [1:0] m);
    logic [7:0] e;
    if (m == TBL_PRE_INC) tp = tp + TP_ONE;
    e = pbyte(tp);
    if (m == TBL_POST_INC) tp = tp + TP_ONE;
    if (m == TBL_POST_DEC) tp = tp - TP_ONE;
    issue({OP_TBL_READ, m});
    chk("table_latch", e, table_latch);
    chk("table_pointer", tp, table_pointer);
  endtask
  initial begin
    void'($urandom(75));
    w = ACC_RESET;
    st = STATUS_RESET;
    tp = TP_RESET;
    repeat (5) @(posedge ref_clk);
    #1 resetn = 1;
    chk("reset accumulator", ACC_RESET, accumulator);
    chk("reset latch", 8'h00, table_latch);
    ext_set_en = 1;
    byte_op(3, ACCESS_LOW_LAST, 1, 0, 8'h53);
    byte_op(2, 8'h60, 1, 0, 8'h19);
    ext_set_en = 0;
    byte_op(1, ACCESS_LOW_LAST, 0, 0, 8'h91);
    for (int m = 0; m < 4; m++) tbl(2'(m));
    tbl(TBL_POST_DEC);
    tbl(TBL_POST_DEC);
    tbl(TBL_PRE_INC);
    // Undecoded word must leave all state alone
    issue(16'hFFFF);
    chk("unknown accumulator", w, accumulator);
    chk("unknown status", st, status);
    chk("unknown pointer", tp, table_pointer);
    for (int i = 0; i < 160; i++) begin
      ext_set_en = 1'($urandom);
      bank_select_register = 4'($urandom);
      index_base = 12'($urandom);
      byte_op($urandom_range(0, 3), 8'($urandom), 1'($urandom), 1'($urandom), 8'($urandom));
      if (i % 5 == 0) tbl(2'($urandom));
    end
    // Reset in mid-run, then restart from reset state
    resetn = 0;
    @(posedge ref_clk) #1;
    @(posedge ref_clk) #1;
    resetn = 1;
    w = ACC_RESET;
    st = STATUS_RESET;
    tp = TP_RESET;
    chk("reset accumulator", w, accumulator);
    chk("reset status", st, status);
    chk("reset pointer", tp, table_pointer);
    chk("reset busy", 0, busy);
    byte_op(0, 8'h35, 1, 0, 8'h00);
    tbl(TBL_POST_INC);
    print_verdict();
  end
endmodule
`default_nettype wire

/* File: exec_chk.sv */
// Purpose: Port-level checks for the byte-op and table-read executor
// Assumes: One clock domain, synchronous active-low reset
// Notes: Bound onto the executor at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module exec_chk
  import byte_exec_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic busy,
  input wire logic data_rd_en,
  input wire logic data_wr_en,
  input wire logic [PADDR_W-1:0] prog_addr,
  input wire logic prog_rd_en,
  input wire logic [DATA_W-1:0] accumulator,
  input wire logic [STATUS_W-1:0] status,
  input wire logic [TP_W-1:0] table_pointer,
  input wire logic [DATA_W-1:0] table_latch
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence read_step;
    busy && data_rd_en ##1 !data_rd_en;
  endsequence
  sequence fetch_step;
    prog_rd_en ##1 !prog_rd_en ##1 !prog_rd_en;
  endsequence
  rd_pulse_a: assert property (data_rd_en |-> read_step)
    else $error("data read is not a single pulse inside busy");
  wr_order_a: assert property (data_wr_en |-> $past(data_rd_en, 2))
    else $error("register write without read two cycles before");
  fetch_pulse_a: assert property (prog_rd_en |-> fetch_step)
    else $error("program read is not a single pulse");
  fetch_addr_a: assert property (prog_rd_en |-> prog_addr == table_pointer[TP_W-1:1])
    else $error("program address differs from pointer word");
  latch_cause_a: assert property ($changed(table_latch) |-> $past(prog_rd_en, 2))
    else $error("table latch changed without a program read");
  idle_hold_a: assert property (!busy |=> $stable(accumulator) && $stable(status))
    else $error("accumulator or flags changed while idle");
  ptr_step_a: assert property ($changed(table_pointer) |->
    table_pointer == $past(table_pointer) + TP_ONE || $past(table_pointer) == table_pointer + TP_ONE)
    else $error("table pointer moved by more than one");
  busy_len_a: assert property ($rose(busy) |-> ##[1:8] !busy)
    else $error("busy held too long");
endmodule
bind byte_op_and_table_read_exec exec_chk exec_chk_i (.ref_clk, .resetn, .busy, .data_rd_en,
  .data_wr_en, .prog_addr, .prog_rd_en, .accumulator, .status, .table_pointer, .table_latch);
`default_nettype wire

/* File: mem_model.sv */
// Purpose: Data and program memory standing beside the executor
// Assumes: Read data is due the clock after each read enable
// Notes: Read lines scramble every cycle when not answering
`timescale 1ns/1ps
`default_nettype none
module mem_model
  import byte_exec_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [DADDR_W-1:0] data_addr,
  input wire logic data_rd_en,
  input wire logic data_wr_en,
  input wire logic [DATA_W-1:0] data_wdata,
  output logic [DATA_W-1:0] data_rdata,
  input wire logic [PADDR_W-1:0] prog_addr,
  input wire logic prog_rd_en,
  output logic [PWORD_W-1:0] prog_rdata
);
  logic [DATA_W-1:0] mem [2**DADDR_W];
  initial begin
    data_rdata = '0;
    prog_rdata = '0;
  end
  always @(posedge ref_clk) begin
    data_rdata <= data_rd_en ? mem[data_addr] : ~data_rdata;
    prog_rdata <= prog_rd_en ? {prog_addr[7:0] ^ 8'hC3, prog_addr[7:0] + 8'h11} : ~prog_rdata;
    if (data_wr_en) mem[data_addr] <= data_wdata;
  end
endmodule
`default_nettype wire
